// >>> rtl/ivs_pkg.sv
// ==================================================================
// constants and types of the interrupt, status and stack block
package ivs_pkg;

  localparam int IVS_NUM_SRC = 19;
  localparam int IVS_PC_W = 16;
  localparam int IVS_SP_W = 12;

  // register indices; byte address is four times the index
  localparam logic [7:0] IVS_IDX_SP_LOW = 8'h3D;
  localparam logic [7:0] IVS_IDX_SP_HIGH = 8'h3E;
  localparam logic [7:0] IVS_IDX_STATUS = 8'h3F;
  localparam logic [7:0] IVS_IDX_IRQ_CTRL = 8'h40;
  localparam logic [7:0] IVS_IDX_IRQ_EN = 8'h41;
  localparam logic [7:0] IVS_IDX_IRQ_PEND = 8'h42;

  // status flag positions
  localparam int IVS_BIT_I = 7;
  localparam int IVS_BIT_T = 6;
  localparam int IVS_BIT_H = 5;
  localparam int IVS_BIT_S = 4;
  localparam int IVS_BIT_V = 3;
  localparam int IVS_BIT_N = 2;
  localparam int IVS_BIT_Z = 1;
  localparam int IVS_BIT_C = 0;

  // control register fields
  localparam int IVS_CTRL_VSEL = 0;
  localparam int IVS_CTRL_APP_LOCK = 1;
  localparam int IVS_CTRL_LDR_LOCK = 2;

  // reset values, vector table start and vector step
  localparam logic [7:0] IVS_STATUS_RST = 8'h00;
  localparam logic [11:0] IVS_SP_RST = 12'h000;
  localparam logic [15:0] IVS_RESET_ADDR = 16'h0000;
  localparam logic [15:0] IVS_VEC_START = 16'h0002;
  localparam logic [15:0] IVS_VEC_STEP = 16'h0002;

  localparam logic [1:0] IVS_RESP_OKAY = 2'h0;
  localparam logic [1:0] IVS_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    IVS_SP_NONE,
    IVS_SP_PUSH1,
    IVS_SP_PUSH2,
    IVS_SP_POP1,
    IVS_SP_POP2
  } ivs_sp_op_t;

  // one cycle of requests from the execution core
  typedef struct packed {
    ivs_sp_op_t sp_op;
    logic return_from_interrupt;
    logic bit_store_instr;
    logic bst_bit;
    logic [7:0] flag_mask;
    logic [7:0] flag_val;
  } ivs_core_req_t;

  // accepted interrupt as seen by the core
  typedef struct packed {
    logic take;
    logic [15:0] vector;
    logic [15:0] ret_addr;
  } ivs_irq_out_t;

endpackage

// >>> rtl/ivs_top.sv
`timescale 1ns/100ps
module ivs_top
  import ivs_pkg::*;
#(
  parameter logic [15:0] BOOT_BASE = 16'h3C00
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire ivs_core_req_t core_req,
  input wire logic core_ready,
  input wire logic [15:0] core_pc,
  input wire logic [IVS_NUM_SRC-1:0] irq_req,
  input wire logic boot_reset_fuse,
  output ivs_irq_out_t irq_out,
  output logic [7:0] status_flags,
  output logic [15:0] stack_pointer,
  output logic [15:0] reset_addr
);

  // ==================================================================
  // state
  logic [11:0] sp;
  logic [2:0] irq_ctrl;
  logic [IVS_NUM_SRC-1:0] irq_en;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_idx;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [7:0] next_status;
  logic [11:0] next_sp;

  // ==================================================================
  // write channel decode
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire [7:0] wr_idx = aw_take ? s_axi_awaddr[9:2] : aw_idx;
  wire [31:0] wr_data = w_take ? s_axi_wdata : w_data;
  wire [3:0] wr_strb = w_take ? s_axi_wstrb : w_strb;
  wire wr_fire = (aw_held || aw_take) && (w_held || w_take);
  wire wr_hi = s_axi_awaddr[31:10] != 22'h0;
  // byte lanes of the enable word, cut to the number of sources
  wire [IVS_NUM_SRC-1:0] en_lanes = IVS_NUM_SRC'({{8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}});
  wire wr_lane0 = wr_fire && wr_strb[0];
  wire wr_status = wr_lane0 && wr_idx == IVS_IDX_STATUS;
  wire wr_sp_low = wr_lane0 && wr_idx == IVS_IDX_SP_LOW;
  wire wr_sp_high = wr_lane0 && wr_idx == IVS_IDX_SP_HIGH;
  wire wr_ctrl = wr_lane0 && wr_idx == IVS_IDX_IRQ_CTRL;
  wire wr_en = wr_fire && wr_idx == IVS_IDX_IRQ_EN;
  wire wr_known = wr_idx inside {IVS_IDX_STATUS, IVS_IDX_SP_LOW, IVS_IDX_SP_HIGH,
                                 IVS_IDX_IRQ_CTRL, IVS_IDX_IRQ_EN, IVS_IDX_IRQ_PEND};

  // ==================================================================
  // interrupt selection
  wire [IVS_NUM_SRC-1:0] pend = irq_req & irq_en;
  logic [IVS_NUM_SRC-1:0] first_hot;
  logic [IVS_NUM_SRC-1:0] lower_pend;

  // lower_pend[i] is set when any source below i is pending
  assign lower_pend[0] = 1'b0;
  genvar gi;
  generate
    for (gi = 0; gi < IVS_NUM_SRC; gi = gi + 1)
    begin : g_prio
      if (gi > 0)
      begin : g_chain
        assign lower_pend[gi] = lower_pend[gi-1] | pend[gi-1];
      end
      assign first_hot[gi] = pend[gi] & ~lower_pend[gi];
    end
  endgenerate

  logic [4:0] first_idx;
  always_comb
  begin
    first_idx = 5'h00;
    for (int k = IVS_NUM_SRC - 1; k >= 0; k--)
    begin
      if (first_hot[k])
      begin
        first_idx = 5'(k);
      end
    end
  end

  // table order: ext0..2, timer2 x2, timer1 x4, timer0 x2, then serial group
  wire [15:0] vec_offset = IVS_VEC_START + 16'({11'h0, first_idx} * IVS_VEC_STEP);
  wire [15:0] vec_base = irq_ctrl[IVS_CTRL_VSEL] ? BOOT_BASE : 16'h0000;
  wire [15:0] vec_addr = vec_base + vec_offset;

  // app lock blocks in application area, loader lock in boot area
  wire in_boot = core_pc >= BOOT_BASE;
  wire lock_block = (irq_ctrl[IVS_CTRL_APP_LOCK] && !in_boot) ||
                    (irq_ctrl[IVS_CTRL_LDR_LOCK] && in_boot);
  wire can_take = status_flags[IVS_BIT_I] && (|pend) && core_ready &&
                  !lock_block && !irq_out.take;

  // ==================================================================
  // status flags
  always_comb
  begin
    next_status = status_flags;
    if (wr_status)
    begin
      next_status = wr_data[7:0];
    end
    // arithmetic and logic flags from the core
    next_status[IVS_BIT_H] = core_req.flag_mask[IVS_BIT_H] ? core_req.flag_val[IVS_BIT_H] : next_status[IVS_BIT_H];
    next_status[IVS_BIT_V] = core_req.flag_mask[IVS_BIT_V] ? core_req.flag_val[IVS_BIT_V] : next_status[IVS_BIT_V];
    next_status[IVS_BIT_N] = core_req.flag_mask[IVS_BIT_N] ? core_req.flag_val[IVS_BIT_N] : next_status[IVS_BIT_N];
    next_status[IVS_BIT_Z] = core_req.flag_mask[IVS_BIT_Z] ? core_req.flag_val[IVS_BIT_Z] : next_status[IVS_BIT_Z];
    next_status[IVS_BIT_C] = core_req.flag_mask[IVS_BIT_C] ? core_req.flag_val[IVS_BIT_C] : next_status[IVS_BIT_C];
    if (core_req.bit_store_instr)
    begin
      next_status[IVS_BIT_T] = core_req.bst_bit;
    end
    if (core_req.return_from_interrupt)
    begin
      next_status[IVS_BIT_I] = 1'b1;
    end
    if (can_take)
    begin
      next_status[IVS_BIT_I] = 1'b0;
    end
    next_status[IVS_BIT_S] = next_status[IVS_BIT_N] ^ next_status[IVS_BIT_V];
  end

  // ==================================================================
  // stack pointer
  always_comb
  begin
    next_sp = sp;
    case (core_req.sp_op)
      IVS_SP_PUSH1: next_sp = sp - 12'h001;
      IVS_SP_PUSH2: next_sp = sp - 12'h002;
      IVS_SP_POP1: next_sp = sp + 12'h001;
      IVS_SP_POP2: next_sp = sp + 12'h002;
      default: next_sp = sp;
    endcase
    if (can_take)
    begin
      next_sp = sp - 12'h002;
    end
    if (wr_sp_low)
    begin
      next_sp[7:0] = wr_data[7:0];
    end
    if (wr_sp_high)
    begin
      next_sp[11:8] = wr_data[3:0];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      status_flags <= IVS_STATUS_RST;
      sp <= IVS_SP_RST;
      stack_pointer <= 16'h0000;
    end
    else
    begin
      status_flags <= next_status;
      sp <= next_sp;
      stack_pointer <= {4'h0, next_sp};
    end
  end

  // ==================================================================
  // interrupt acceptance
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_out <= '0;
    end
    else
    begin
      irq_out.take <= can_take;
      if (can_take)
      begin
        irq_out.vector <= vec_addr;
        irq_out.ret_addr <= core_pc;
      end
    end
  end

  // fuse is caught by the clock while reset is held
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      reset_addr <= boot_reset_fuse ? BOOT_BASE : IVS_RESET_ADDR;
    end
  end

  // ==================================================================
  // control registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_ctrl <= 3'h0;
      irq_en <= '0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        irq_ctrl <= wr_data[2:0];
      end
      if (wr_en)
      begin
        irq_en <= (irq_en & ~en_lanes) | (wr_data[IVS_NUM_SRC-1:0] & en_lanes);
      end
    end
  end

  // ==================================================================
  // write channel
  // ready is registered, so it is worked out from the next state
  wire next_aw_held = !wr_fire && (aw_held || aw_take);
  wire next_w_held = !wr_fire && (w_held || w_take);
  wire next_bvalid = wr_fire || (s_axi_bvalid && !s_axi_bready);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_idx <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= IVS_RESP_OKAY;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !next_aw_held && !next_bvalid;
      s_axi_wready <= !next_w_held && !next_bvalid;
      if (wr_fire)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_known && !(aw_take && wr_hi)) ? IVS_RESP_OKAY : IVS_RESP_SLVERR;
      end
      else
      begin
        if (aw_take)
        begin
          aw_held <= 1'b1;
          aw_idx <= wr_hi ? 8'hFF : s_axi_awaddr[9:2];
        end
        if (w_take)
        begin
          w_held <= 1'b1;
          w_data <= s_axi_wdata;
          w_strb <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready)
        begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end


  // ==================================================================
  // read channel
  wire [7:0] rd_idx = s_axi_araddr[9:2];
  wire rd_hi = s_axi_araddr[31:10] != 22'h0;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire next_rvalid = ar_take || (s_axi_rvalid && !s_axi_rready);
  logic [31:0] rd_mux;
  logic rd_ok;
  always_comb
  begin
    rd_ok = !rd_hi;
    case (rd_idx)
      IVS_IDX_STATUS: rd_mux = {24'h000000, status_flags};
      IVS_IDX_SP_LOW: rd_mux = {24'h000000, sp[7:0]};
      IVS_IDX_SP_HIGH: rd_mux = {28'h0000000, sp[11:8]};
      IVS_IDX_IRQ_CTRL: rd_mux = {29'h0, irq_ctrl};
      IVS_IDX_IRQ_EN: rd_mux = {13'h0, irq_en};
      IVS_IDX_IRQ_PEND: rd_mux = {13'h0, pend};
      default:
      begin
        rd_mux = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= IVS_RESP_OKAY;
      s_axi_arready <= 1'b0;
    end
    else
    begin
      s_axi_arready <= !next_rvalid;
      s_axi_rvalid <= next_rvalid;
      if (ar_take)
      begin
        s_axi_rdata <= rd_ok ? rd_mux : 32'h0000_0000;
        s_axi_rresp <= rd_ok ? IVS_RESP_OKAY : IVS_RESP_SLVERR;
      end
    end
  end

  // ==================================================================
  // checks
  sequence s_accept;
    can_take;
  endsequence

  sequence s_entered;
    irq_out.take && !status_flags[IVS_BIT_I];
  endsequence

  property p_no_take_without_global;
    @(posedge aclk) disable iff (!aresetn)
    !status_flags[IVS_BIT_I] |=> !irq_out.take;
  endproperty
  a_no_take_without_global: assert property (p_no_take_without_global)
    else $error("interrupt taken with global enable clear");

  property p_take_clears_global;
    @(posedge aclk) disable iff (!aresetn)
    s_accept |=> s_entered;
  endproperty
  a_take_clears_global: assert property (p_take_clears_global)
    else $error("global enable not cleared on accept");

  property p_return_from_interrupt_sets_global;
    @(posedge aclk) disable iff (!aresetn)
    core_req.return_from_interrupt && !can_take |=> status_flags[IVS_BIT_I];
  endproperty
  a_return_from_interrupt_sets_global: assert property (p_return_from_interrupt_sets_global)
    else $error("return did not set global enable");

  property p_bit_store;
    @(posedge aclk) disable iff (!aresetn)
    core_req.bit_store_instr |=> status_flags[IVS_BIT_T] == $past(core_req.bst_bit);
  endproperty
  a_bit_store: assert property (p_bit_store)
    else $error("copy bit not stored");

  property p_sign;
    @(posedge aclk) disable iff (!aresetn)
    status_flags[IVS_BIT_S] == (status_flags[IVS_BIT_N] ^ status_flags[IVS_BIT_V]);
  endproperty
  a_sign: assert property (p_sign)
    else $error("sign flag not negative xor overflow");

  property p_carry;
    @(posedge aclk) disable iff (!aresetn)
    core_req.flag_mask[IVS_BIT_C] |=> status_flags[IVS_BIT_C] == $past(core_req.flag_val[IVS_BIT_C]);
  endproperty
  a_carry: assert property (p_carry)
    else $error("carry flag not recorded");

  property p_push_two;
    @(posedge aclk) disable iff (!aresetn)
    s_accept and !wr_sp_low and !wr_sp_high |=> sp == $past(sp) - 12'h002;
  endproperty
  a_push_two: assert property (p_push_two)
    else $error("accept did not lower stack by two");

  property p_pop_one;
    @(posedge aclk) disable iff (!aresetn)
    core_req.sp_op == IVS_SP_POP1 && !can_take && !wr_sp_low && !wr_sp_high |=> sp == $past(sp) + 12'h001;
  endproperty
  a_pop_one: assert property (p_pop_one)
    else $error("pop did not raise stack by one");

  property p_sp_upper_zero;
    @(posedge aclk) disable iff (!aresetn)
    wr_sp_high |=> stack_pointer[15:12] == 4'h0 && sp[11:8] == $past(wr_data[3:0]);
  endproperty
  a_sp_upper_zero: assert property (p_sp_upper_zero)
    else $error("upper stack bits not zero");

  property p_vector_priority;
    @(posedge aclk) disable iff (!aresetn)
    s_accept and (pend[0] && !irq_ctrl[IVS_CTRL_VSEL]) |=> irq_out.vector == 16'h0002;
  endproperty
  a_vector_priority: assert property (p_vector_priority)
    else $error("external request 0 not served first");

endmodule

// >>> test/irq_vector_status_stack_bench.sv
`timescale 1ns/100ps
// ==========
// bench for the interrupt, status and stack block
module irq_vector_status_stack_bench;
  import ivs_pkg::*;
  localparam logic [15:0] BB = 16'h3C00;
  logic aclk = 0, aresetn = 0, fuse = 0;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  ivs_core_req_t core_req;
  logic core_ready;
  logic [15:0] core_pc, stack_pointer, reset_addr, base = 16'h0002, sp_exp = 0;
  logic [18:0] irq_req, en_exp = 19'h7FFFF, m;
  ivs_irq_out_t irq_out;
  logic [7:0] status_flags, st, v;
  logic i_exp = 0;
  logic [33:0] rq[$];
  logic [31:0] tq[$];
  logic [33:0] re;
  logic [31:0] te;
  ivs_core_req_t r;
  integer seed;
  int num_errors = 0, total_checks = 0;
  always #2.5 aclk = ~aclk;
  ivs_top #(.BOOT_BASE(BB)) i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .core_req(core_req), .core_ready(core_ready),
    .core_pc(core_pc), .irq_req(irq_req), .boot_reset_fuse(fuse), .irq_out(irq_out),
    .status_flags(status_flags), .stack_pointer(stack_pointer), .reset_addr(reset_addr));
  ivs_core_model i_core (.aclk(aclk), .irq_out(irq_out), .core_req(core_req),
    .core_ready(core_ready), .core_pc(core_pc), .irq_req(irq_req));
  // ==========
  // checking
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    begin
      total_checks++;
      if (s !== e)
      begin
        num_errors++;
        $display("wrong value %s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  task automatic results();
    begin
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  always @(posedge aclk)
    if (rvalid === 1'b1 && rready === 1'b1)
    begin
      re = rq.pop_front();
      chk("rdata", re[31:0], rdata);
      chk("rresp", 32'(re[33:32]), 32'(rresp));
    end
  always @(posedge aclk)
    if (aresetn === 1'b1 && irq_out.take === 1'b1)
    begin
      if (tq.size() == 0)
        chk("take", 32'h0, 32'h1);
      else
      begin
        te = tq.pop_front();
        chk("vector", 32'(te[31:16]), 32'(irq_out.vector));
        chk("ret_addr", 32'(te[15:0]), 32'(irq_out.ret_addr));
      end
    end
  initial
  begin
    #100000;
    num_errors++;
    results();
  end
  // ==========
  // bus master
  task automatic axi_wr(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] er);
    logic aw, w;
    begin
      aw = 1;
      w = 1;
      awaddr <= {22'h0, idx, 2'b00};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      @(posedge aclk);
      while (bvalid !== 1'b1)
      begin
        if (aw && awready === 1'b1)
        begin
          aw = 0;
          awvalid <= 1'b0;
        end
        if (w && wready === 1'b1)
        begin
          w = 0;
          wvalid <= 1'b0;
        end
        @(posedge aclk);
      end
      bready <= 1'b0;
      chk("bresp", 32'(er), 32'(bresp));
      @(posedge aclk);
    end
  endtask
  task automatic axi_rd(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] er);
    begin
      rq.push_back({er, d});
      araddr <= {22'h0, idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      @(posedge aclk);
      while (rvalid !== 1'b1)
      begin
        if (arready === 1'b1)
          arvalid <= 1'b0;
        @(posedge aclk);
      end
      rready <= 1'b0;
      @(posedge aclk);
    end
  endtask
  // ==========
  // one interrupt attempt, with return when taken
  task automatic try(input logic [18:0] mk, input logic [15:0] pc, input logic tk);
    int lo;
    begin
      lo = 0;
      while (lo < 18 && !(mk[lo] & en_exp[lo]))
        lo++;
      if (tk)
      begin
        tq.push_back({base + 16'(2 * lo), pc});
        sp_exp -= 16'h2;
        i_exp = 1'b0;
      end
      i_core.raise(mk, pc);
      repeat (4) @(posedge aclk);
      i_core.drop();
      @(posedge aclk);
      chk("stack_pointer", 32'(sp_exp), 32'(stack_pointer));
      chk("global enable", 32'(i_exp), 32'(status_flags[IVS_BIT_I]));
      if (tk)
      begin
        r = '0;
        r.sp_op = IVS_SP_POP2;
        r.return_from_interrupt = 1'b1;
        i_core.step(r);
        sp_exp += 16'h2;
        i_exp = 1'b1;
        @(posedge aclk);
        chk("stack_pointer", 32'(sp_exp), 32'(stack_pointer));
        chk("global enable", 32'(i_exp), 32'(status_flags[IVS_BIT_I]));
      end
    end
  endtask
  // ==========
  // main sequence
  initial
  begin
    seed = 32'hAECE0C6F;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("reset_addr", 32'h0, 32'(reset_addr));
    chk("stack_pointer", 32'h0, 32'(stack_pointer));
    axi_rd(IVS_IDX_SP_HIGH, 32'h0, IVS_RESP_OKAY);
    axi_rd(IVS_IDX_STATUS, 32'h0, IVS_RESP_OKAY);
    axi_wr(IVS_IDX_SP_HIGH, 32'hFF, IVS_RESP_OKAY);
    axi_rd(IVS_IDX_SP_HIGH, 32'h0F, IVS_RESP_OKAY);
    axi_rd(8'h50, 32'h0, IVS_RESP_SLVERR);
    axi_wr(8'h50, 32'h1, IVS_RESP_SLVERR);
    axi_wr(IVS_IDX_SP_HIGH, 32'h08, IVS_RESP_OKAY);
    axi_wr(IVS_IDX_SP_LOW, 32'h5F, IVS_RESP_OKAY);
    axi_rd(IVS_IDX_SP_LOW, 32'h5F, IVS_RESP_OKAY);
    sp_exp = 16'h085F;
    for (int k = 0; k < 6; k++)
    begin
      v = 8'($random(seed));
      r = '0;
      r.flag_mask = 8'h2F;
      r.flag_val = v;
      r.bit_store_instr = 1'b1;
      r.bst_bit = v[7];
      i_core.step(r);
      @(posedge aclk);
      st = (v & 8'h2F) | {1'b0, v[7], 1'b0, v[2] ^ v[3], 4'h0};
      chk("status_flags", 32'(st), 32'(status_flags));
    end
    for (int k = 0; k < 4; k++)
    begin
      r = '0;
      r.sp_op = ivs_sp_op_t'(k + 1);
      i_core.step(r);
      sp_exp += (k == 0) ? 16'hFFFF : (k == 1) ? 16'hFFFE : (k == 2) ? 16'h1 : 16'h2;
      @(posedge aclk);
      chk("stack_pointer", 32'(sp_exp), 32'(stack_pointer));
    end
    axi_wr(IVS_IDX_IRQ_EN, 32'h7FFFF, IVS_RESP_OKAY);
    axi_rd(IVS_IDX_IRQ_EN, 32'h7FFFF, IVS_RESP_OKAY);
    axi_wr(IVS_IDX_STATUS, 32'h80, IVS_RESP_OKAY);
    i_exp = 1'b1;
    for (int i = 0; i < 19; i++)
    begin
      if (i == 12)
      begin
        axi_wr(IVS_IDX_IRQ_CTRL, 32'h1, IVS_RESP_OKAY);
        axi_rd(IVS_IDX_IRQ_CTRL, 32'h1, IVS_RESP_OKAY);
        base = BB + 16'h2;
      end
      m = (19'($random(seed)) << (i + 1)) | (19'h1 << i);
      try(m, 16'h0100 + 16'(i), 1'b1);
    end
    axi_wr(IVS_IDX_STATUS, 32'h0, IVS_RESP_OKAY);
    i_exp = 1'b0;
    i_core.raise(19'h7FFFF, 16'h0100);
    axi_rd(IVS_IDX_IRQ_PEND, 32'h7FFFF, IVS_RESP_OKAY);
    try(19'h7FFFF, 16'h0100, 1'b0);
    axi_wr(IVS_IDX_STATUS, 32'h80, IVS_RESP_OKAY);
    i_exp = 1'b1;
    en_exp = 19'h7FFFE;
    axi_wr(IVS_IDX_IRQ_EN, 32'h7FFFE, IVS_RESP_OKAY);
    try(19'h1, 16'h0100, 1'b0);
    try(19'h3, 16'h0100, 1'b1);
    for (int k = 0; k < 3; k++)
    begin
      axi_wr(IVS_IDX_IRQ_CTRL, (k == 0) ? 32'h3 : 32'h5, IVS_RESP_OKAY);
      try(19'h6, (k == 1) ? BB + 16'h10 : 16'h0100, k == 2);
    end
    fuse <= 1'b1;
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("reset_addr", 32'(BB), 32'(reset_addr));
    chk("status_flags", 32'h0, 32'(status_flags));
    chk("stack_pointer", 32'h0, 32'(stack_pointer));
    chk("pending", 32'h0, 32'(tq.size() + rq.size()));
    results();
  end
endmodule

// >>> test/ivs_core_model.sv
`timescale 1ns/100ps
// ==========
// execution core and request sources
module ivs_core_model
  import ivs_pkg::*;
(
  input wire logic aclk,
  input wire ivs_irq_out_t irq_out,
  output ivs_core_req_t core_req,
  output logic core_ready,
  output logic [15:0] core_pc,
  output logic [IVS_NUM_SRC-1:0] irq_req
);
  initial
  begin
    core_req = '0;
    core_ready = 1'b0;
    core_pc = 16'h0100;
    irq_req = '0;
  end
  // leave the boundary and clear all sources once the vector is taken
  always @(posedge aclk)
    if (irq_out.take === 1'b1)
    begin
      core_ready <= 1'b0;
      irq_req <= '0;
    end
  // one instruction, requests held for one cycle
  task automatic step(input ivs_core_req_t r);
    begin
      core_req <= r;
      @(posedge aclk);
      core_req <= '0;
    end
  endtask
  task automatic raise(input logic [18:0] m, input logic [15:0] pc);
    begin
      irq_req <= m;
      core_pc <= pc;
      core_ready <= 1'b1;
    end
  endtask
  task automatic drop();
    begin
      irq_req <= '0;
      core_ready <= 1'b0;
    end
  endtask
endmodule
